// ===== pkg/pwmreg_pkg.sv
package pwmreg_pkg;
    // ------------------------------------------------------------
    // Register map (word index on the 2-bit address)
    // ------------------------------------------------------------
    localparam int PWMREG_AW = 2;
    localparam int PWMREG_DW = 32;
    localparam logic [1:0] PWMREG_IDX_PERIOD = 2'h0;
    localparam logic [1:0] PWMREG_IDX_LOW = 2'h1;
    localparam logic [1:0] PWMREG_IDX_ENABLE = 2'h2;
    localparam logic [1:0] PWMREG_IDX_RSVD = 2'h3;
    localparam int PWMREG_EN_BIT = 0;
    localparam logic [31:0] PWMREG_ZERO = 32'h0000_0000;
    localparam logic [31:0] PWMREG_PERIOD_INIT = 32'h0000_0010;
    localparam logic [31:0] PWMREG_LOW_INIT = 32'h0000_0008;

    // ------------------------------------------------------------
    // Host-side AXI4-Lite register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] PWMREG_AXI_CMD = 4'h0;
    localparam logic [3:0] PWMREG_AXI_WDATA = 4'h4;
    localparam logic [3:0] PWMREG_AXI_RDATA = 4'h8;
    localparam logic [3:0] PWMREG_AXI_STAT = 4'hc;
    localparam int PWMREG_CMD_GO = 0;
    localparam int PWMREG_CMD_WR = 1;
    localparam int PWMREG_CMD_ADDR_LSB = 4;
    localparam logic [1:0] PWMREG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWMREG_RESP_SLVERR = 2'h2;
endpackage : pwmreg_pkg

// ===== pkg/pwmreg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pwmreg_if;
    logic chip_select;
    logic [1:0] address;
    logic write;
    logic [31:0] write_data;
    logic read;
    logic [31:0] read_data;

    modport device (
        input chip_select, address, write, write_data, read,
        output read_data
    );
    modport host (
        output chip_select, address, write, write_data, read,
        input read_data
    );
endinterface : pwmreg_if
`default_nettype wire

// ===== verilog/pwmreg_counter.sv
`timescale 1ns/10ps
`default_nettype none
module pwmreg_counter import pwmreg_pkg::*; #(
    parameter int WIDTH = 32
) (
    input wire logic aclk,               // Clock
    input wire logic aresetn,            // Sync reset, active low
    input wire logic enable,             // Run enable
    input wire logic [WIDTH-1:0] period, // Wrap length
    input wire logic [WIDTH-1:0] low,    // Low-time count
    output logic wave                    // Registered output
);
    // Wrap compare needs at least two count bits
    if (WIDTH < 2) begin : g_width_check
        $error("pwmreg_counter: WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic wave;
    } pwmreg_cnt_t;

    pwmreg_cnt_t st;
    pwmreg_cnt_t next_st;

    always_comb begin
        next_st = st;
        if (!enable) begin
            // (RULE16) Halted, held low
            next_st.count = '0;
            next_st.wave = 1'b0;
        end else begin
            // (RULE3) Compare against low time
            next_st.wave = (st.count > low);
            // (RULE2) Wrap after period counts
            if (st.count >= period - WIDTH'(1)) begin
                next_st.count = '0;
            end else begin
                next_st.count = st.count + WIDTH'(1);
            end
        end
    end

    // (RULE1) Single clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wave = st.wave;
endmodule : pwmreg_counter
`default_nettype wire

// ===== verilog/pwmreg_device.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (RULE1) One clock for modulation and registers
// (RULE2) 32-bit counter wraps at period count
// (RULE3) Output low while count at/below low-time
// (RULE4) Period count register at word 0
// (RULE5) Low-time count register at word 1
// (RULE6) Enable bit 0 at word 2
// (RULE7) Word 3 reserved, no register
// (RULE8) All three registers read back written values
// (RULE9) Every access completes, no wait states
// (RULE10) Read data in same cycle as request
// (RULE11) No setup or hold cycles
// (RULE12) Two-bit word address, one register each at words 0-2
// (RULE13) Select plus read/write strobes, 32-bit data
// (RULE14) Reset driven active low by system
// (RULE15) Period and low-time reset from parameters
// (RULE16) Disabled: output low, counter zero
// (RULE17) Reserved reads zero; enable upper bits zero
module pwmreg_device import pwmreg_pkg::*; #(
    parameter logic [31:0] PERIOD_INIT = PWMREG_PERIOD_INIT, // Initial period
    parameter logic [31:0] LOW_INIT = PWMREG_LOW_INIT        // Initial low time
) (
    input wire logic aclk,      // Clock
    input wire logic aresetn,   // Sync reset, active low
    pwmreg_if.device bus,       // Register port
    output logic pwm_out        // Modulated output
);
    typedef struct packed {
        logic [31:0] period_count;
        logic [31:0] low_time_count;
        logic output_enable;
    } pwmreg_dev_t;

    pwmreg_dev_t st;
    pwmreg_dev_t next_st;
    logic wr_hit;

    assign wr_hit = bus.chip_select && bus.write;

    always_comb begin
        next_st = st;
        // (RULE11) Write taken in its own cycle
        if (wr_hit) begin
            case (bus.address)
                // (RULE4) Period register
                PWMREG_IDX_PERIOD: next_st.period_count = bus.write_data;
                // (RULE5) Low-time register
                PWMREG_IDX_LOW: next_st.low_time_count = bus.write_data;
                // (RULE6) Enable bit
                PWMREG_IDX_ENABLE: next_st.output_enable = bus.write_data[PWMREG_EN_BIT];
                // (RULE7) Reserved write ignored
                default: next_st = st;
            endcase
        end
    end

    // (RULE15) Parameter-loaded reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.period_count <= PERIOD_INIT;
            st.low_time_count <= LOW_INIT;
            st.output_enable <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // (RULE10) Combinational read, zero latency
    always_comb begin
        bus.read_data = PWMREG_ZERO;
        if (bus.chip_select && bus.read) begin
            case (bus.address)
                // (RULE8) Read back
                PWMREG_IDX_PERIOD: bus.read_data = st.period_count;
                PWMREG_IDX_LOW: bus.read_data = st.low_time_count;
                // (RULE17) Upper enable bits zero
                PWMREG_IDX_ENABLE: bus.read_data = {31'h0, st.output_enable};
                default: bus.read_data = PWMREG_ZERO;
            endcase
        end
    end

    pwmreg_counter #(
        .WIDTH(32)
    ) u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(st.output_enable),
        .period(st.period_count),
        .low(st.low_time_count),
        .wave(pwm_out)
    );
endmodule : pwmreg_device
`default_nettype wire

// ===== verilog/pwmreg_host.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pwmreg_host import pwmreg_pkg::*; (
    input wire logic aclk,             // Clock
    input wire logic aresetn,          // Sync reset, active low
    pwmreg_if.host bus,                // Register port
    input wire logic [3:0] awaddr,     // AXI write address
    input wire logic awvalid,          // AXI
    output logic awready,              // AXI
    input wire logic [31:0] wdata,     // AXI write data
    input wire logic [3:0] wstrb,      // AXI byte enables
    input wire logic wvalid,           // AXI
    output logic wready,               // AXI
    output logic [1:0] bresp,          // AXI
    output logic bvalid,               // AXI
    input wire logic bready,           // AXI
    input wire logic [3:0] araddr,     // AXI read address
    input wire logic arvalid,          // AXI
    output logic arready,              // AXI
    output logic [31:0] rdata,         // AXI read data
    output logic [1:0] rresp,          // AXI
    output logic rvalid,               // AXI
    input wire logic rready            // AXI
);
    typedef struct packed {
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] cmd_addr;
        logic cmd_wr;
        logic [31:0] cmd_wdata;
        logic [31:0] cmd_rdata;
        logic done;
        logic go;
        logic cs;
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [31:0] wd;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } pwmreg_host_t;

    pwmreg_host_t st;
    pwmreg_host_t next_st;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    always_comb begin
        next_st = st;
        next_st.go = 1'b0;
        next_st.cs = 1'b0;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
        // (RULE13) Strobed port transfer, one cycle
        if (st.go) begin
            next_st.cs = 1'b1;
            next_st.wr = st.cmd_wr;
            next_st.rd = !st.cmd_wr;
            next_st.addr = st.cmd_addr;
            next_st.wd = st.cmd_wdata;
        end
        // (RULE10) Sample read data in request cycle
        if (st.cs) begin
            if (st.rd) next_st.cmd_rdata = bus.read_data;
            // (RULE9) No wait state expected
            next_st.done = 1'b1;
        end
        if (awvalid && awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_got = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = PWMREG_RESP_OKAY;
            case (st.aw_addr)
                PWMREG_AXI_CMD: begin
                    next_st.cmd_wr = st.w_data[PWMREG_CMD_WR];
                    // (RULE12) Word address field
                    next_st.cmd_addr = st.w_data[PWMREG_CMD_ADDR_LSB +: 2];
                    if (st.w_strb[0] && st.w_data[PWMREG_CMD_GO] && !st.go && !st.cs) begin
                        next_st.go = 1'b1;
                        next_st.done = 1'b0;
                    end
                end
                PWMREG_AXI_WDATA: next_st.cmd_wdata = merge(st.cmd_wdata, st.w_data, st.w_strb);
                PWMREG_AXI_RDATA: next_st.bresp = PWMREG_RESP_OKAY;
                PWMREG_AXI_STAT: next_st.bresp = PWMREG_RESP_OKAY;
                default: next_st.bresp = PWMREG_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && bready) next_st.bvalid = 1'b0;
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = PWMREG_RESP_OKAY;
            case (araddr)
                PWMREG_AXI_CMD: next_st.rdata = {26'h0, st.cmd_addr, 2'h0, st.cmd_wr, 1'b0};
                PWMREG_AXI_WDATA: next_st.rdata = st.cmd_wdata;
                PWMREG_AXI_RDATA: next_st.rdata = st.cmd_rdata;
                PWMREG_AXI_STAT: next_st.rdata = {31'h0, st.done};
                default: begin
                    next_st.rdata = PWMREG_ZERO;
                    next_st.rresp = PWMREG_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        // Ready flags kept in flops so every AXI output is registered
        next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
        next_st.w_rdy = !next_st.w_got && !next_st.bvalid;
        next_st.ar_rdy = !next_st.rvalid;
    end

    // (RULE14) Active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign awready = st.aw_rdy;
    assign wready = st.w_rdy;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.ar_rdy;
    assign rvalid = st.rvalid;
    assign rresp = st.rresp;
    assign rdata = st.rdata;
    assign bus.chip_select = st.cs;
    assign bus.write = st.wr;
    assign bus.read = st.rd;
    assign bus.address = st.addr;
    assign bus.write_data = st.wd;
endmodule : pwmreg_host
`default_nettype wire

// ===== verif/pwmreg_props.sv
`timescale 1ns/10ps
`default_nettype none
module pwmreg_props import pwmreg_pkg::*; #(
    parameter logic [31:0] PERIOD_INIT = PWMREG_PERIOD_INIT, // Initial period
    parameter logic [31:0] LOW_INIT = PWMREG_LOW_INIT // Initial low time
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset
    input wire logic chip_select, // Select
    input wire logic [1:0] address, // Word index
    input wire logic write, // Write strobe
    input wire logic [31:0] write_data, // Write data
    input wire logic read, // Read strobe
    input wire logic [31:0] read_data, // Read data
    input wire logic pwm_out // Modulated output
);
    // ------------------------------------------------------------
    // Shadow of the device registers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] per;
        logic [31:0] low;
        logic en;
        logic en_d;
    } pwmreg_shadow_t;
    pwmreg_shadow_t st;
    pwmreg_shadow_t next_st;
    logic rd;
    assign rd = chip_select && read;
    always_comb begin
        next_st = st;
        next_st.en_d = st.en;
        if (chip_select && write) begin
            case (address)
                PWMREG_IDX_PERIOD: next_st.per = write_data;
                PWMREG_IDX_LOW: next_st.low = write_data;
                PWMREG_IDX_ENABLE: next_st.en = write_data[PWMREG_EN_BIT];
                default: ;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) st <= '{PERIOD_INIT, LOW_INIT, 1'b0, 1'b0};
        else st <= next_st;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_period_read: assert property (rd && address == 2'h0 |-> read_data == st.per)
        else $error("period readback wrong");
    a_low_read: assert property (rd && address == 2'h1 |-> read_data == st.low)
        else $error("low time readback wrong");
    a_enable_read: assert property (rd && address == 2'h2 |-> read_data == {31'h0, st.en})
        else $error("enable readback wrong");
    a_rsvd_zero: assert property (rd && address == 2'h3 |-> read_data == PWMREG_ZERO)
        else $error("reserved word not zero");
    a_idle_zero: assert property (!rd |-> read_data == PWMREG_ZERO)
        else $error("read data without read");
    a_off_low: assert property (!st.en && !st.en_d |-> !pwm_out)
        else $error("output high while disabled");
    a_strobe_pulse: assert property (chip_select && (read || write) |=> !(read || write))
        else $error("strobe longer than one cycle");
    a_strobe_sel: assert property (read || write |-> chip_select && !(read && write))
        else $error("strobe without select");
endmodule : pwmreg_props
`default_nettype wire

// ===== verif/pwm_slave_with_registers_test.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_slave_with_registers_test import pwmreg_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pwm_out;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] wr_resp;
    logic [1:0] rd_resp;
    int error_cnt = 0;
    int compares = 0;
    pwmreg_if bus_if ();
    pwmreg_device pwmreg_device_i (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .pwm_out(pwm_out));
    pwmreg_host pwmreg_host_i (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    pwmreg_props #(.PERIOD_INIT(PWMREG_PERIOD_INIT), .LOW_INIT(PWMREG_LOW_INIT)) pwmreg_props_i (
        .aclk(aclk), .aresetn(aresetn), .chip_select(bus_if.chip_select),
        .address(bus_if.address), .write(bus_if.write), .write_data(bus_if.write_data),
        .read(bus_if.read), .read_data(bus_if.read_data), .pwm_out(pwm_out));
    always #2.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    task automatic port_go(input logic [31:0] cmd);
        logic [31:0] s;
        axi_wr(PWMREG_AXI_CMD, cmd);
        check({30'h0, wr_resp}, {30'h0, PWMREG_RESP_OKAY}, "command response");
        s = 32'h0;
        for (int i = 0; i < 20 && !s[0]; i++) axi_rd(PWMREG_AXI_STAT, s);
        check({31'h0, s[0]}, 32'h1, "port done");
    endtask : port_go
    task automatic port_wr(input logic [1:0] a, input logic [31:0] d);
        axi_wr(PWMREG_AXI_WDATA, d);
        port_go({26'h0, a, 4'h3});
    endtask : port_wr
    task automatic port_rd(input logic [1:0] a, output logic [31:0] d);
        port_go({26'h0, a, 4'h1});
        axi_rd(PWMREG_AXI_RDATA, d);
        check({30'h0, rd_resp}, {30'h0, PWMREG_RESP_OKAY}, "read response");
    endtask : port_rd
    task automatic test_reset;
        logic [31:0] d;
        port_rd(PWMREG_IDX_PERIOD, d);
        check(d, PWMREG_PERIOD_INIT, "period init");
        port_rd(PWMREG_IDX_LOW, d);
        check(d, PWMREG_LOW_INIT, "low init");
        port_rd(PWMREG_IDX_ENABLE, d);
        check(d, PWMREG_ZERO, "enable init");
        check({31'h0, pwm_out}, PWMREG_ZERO, "idle output");
        $display("test reset done");
    endtask : test_reset
    task automatic test_regs;
        logic [31:0] pat [4];
        logic [31:0] exp [4];
        logic [31:0] d;
        pat = '{32'h1234_5678, 32'h8765_4321, 32'hffff_ffff, 32'hdead_beef};
        exp = '{32'h1234_5678, 32'h8765_4321, 32'h0000_0001, PWMREG_ZERO};
        for (int a = 0; a < 4; a++) port_wr(2'(a), pat[a]);
        for (int a = 0; a < 4; a++) begin
            port_rd(2'(a), d);
            check(d, exp[a], "register readback");
        end
        $display("test regs done");
    endtask : test_regs
    task automatic test_wave(input logic [31:0] low, input int zeros, input int rises);
        int z;
        int r;
        logic prev;
        port_wr(PWMREG_IDX_ENABLE, PWMREG_ZERO);
        port_wr(PWMREG_IDX_PERIOD, 32'h6);
        port_wr(PWMREG_IDX_LOW, low);
        port_wr(PWMREG_IDX_ENABLE, 32'h1);
        repeat (12) @(posedge aclk);
        z = 0;
        r = 0;
        prev = pwm_out;
        repeat (60) begin
            @(posedge aclk);
            z += int'(pwm_out === 1'b0);
            r += int'(pwm_out === 1'b1 && prev === 1'b0);
            prev = pwm_out;
        end
        check(32'(z), 32'(zeros), "low cycles");
        check(32'(r), 32'(rises), "periods");
        $display("test wave done");
    endtask : test_wave
    task automatic test_slverr;
        logic [31:0] d;
        axi_wr(4'h1, 32'h0000_0001);
        check({30'h0, wr_resp}, {30'h0, PWMREG_RESP_SLVERR}, "unaligned write");
        axi_rd(4'h2, d);
        check({30'h0, rd_resp}, {30'h0, PWMREG_RESP_SLVERR}, "unaligned read");
        check(d, PWMREG_ZERO, "unaligned read data");
        $display("test slverr done");
    endtask : test_slverr
    task automatic test_off;
        int h;
        port_wr(PWMREG_IDX_ENABLE, PWMREG_ZERO);
        h = 0;
        repeat (30) begin
            @(posedge aclk);
            h += int'(pwm_out !== 1'b0);
        end
        check(32'(h), 32'h0, "output while disabled");
        $display("test off done");
    endtask : test_off
    task automatic stop_test;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset;
        test_regs;
        test_wave(32'h2, 30, 10);
        test_wave(32'h0, 10, 10);
        test_wave(32'h4, 50, 10);
        test_wave(32'h5, 60, 0);
        test_slverr;
        test_off;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("Error at %0t: timeout", $time);
        stop_test;
    end
endmodule : pwm_slave_with_registers_test
`default_nettype wire
